// >>> design/spc_pkg.sv
// shared constants for the link primitive codec
package spc_pkg;

  // control and data character codes, 8-bit value before 8b/10b
  localparam logic [7:0] K28_3 = 8'h7C;
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [7:0] K28_6 = 8'hDC;
  localparam logic [7:0] D01_3 = 8'h61;
  localparam logic [7:0] D01_4 = 8'h81;
  localparam logic [7:0] D02_0 = 8'h02;
  localparam logic [7:0] D04_7 = 8'hE4;
  localparam logic [7:0] D07_0 = 8'h07;
  localparam logic [7:0] D07_3 = 8'h67;
  localparam logic [7:0] D10_2 = 8'h4A;
  localparam logic [7:0] D10_5 = 8'hAA;
  localparam logic [7:0] D16_7 = 8'hF0;
  localparam logic [7:0] D21_4 = 8'h95;
  localparam logic [7:0] D21_5 = 8'hB5;
  localparam logic [7:0] D21_6 = 8'hD5;
  localparam logic [7:0] D21_7 = 8'hF5;
  localparam logic [7:0] D22_1 = 8'h36;
  localparam logic [7:0] D24_0 = 8'h18;
  localparam logic [7:0] D25_4 = 8'h99;
  localparam logic [7:0] D27_3 = 8'h7B;
  localparam logic [7:0] D27_4 = 8'h9B;
  localparam logic [7:0] D29_7 = 8'hFD;
  localparam logic [7:0] D30_0 = 8'h1E;
  localparam logic [7:0] D31_4 = 8'h9F;

  // primitive codes seen at the user ports
  typedef enum logic [4:0] {
    PRIM_NONE       = 5'h00,
    PRIM_ALIGN0     = 5'h01,
    PRIM_ALIGN1     = 5'h02,
    PRIM_ALIGN2     = 5'h03,
    PRIM_ALIGN3     = 5'h04,
    PRIM_HARD_RESET = 5'h05,
    PRIM_ERROR      = 5'h06,
    PRIM_BREAK      = 5'h07,
    PRIM_CLOSE      = 5'h08,
    PRIM_EOAF       = 5'h09,
    PRIM_AIP_CONN   = 5'h0A,
    PRIM_AIP_DEV    = 5'h0B,
    PRIM_AIP_PART   = 5'h0C,
    PRIM_AIP_RSVP   = 5'h0D,
    PRIM_BC_CHANGE  = 5'h0E,
    PRIM_BC_RSVC0   = 5'h0F,
    PRIM_BC_RSVC1   = 5'h10,
    PRIM_STP_CONT   = 5'h11,
    PRIM_STP_DMAT   = 5'h12,
    PRIM_STP_EOF    = 5'h13,
    PRIM_STP_HOLD   = 5'h14,
    PRIM_STP_HOLDA  = 5'h15,
    PRIM_STP_PMACK  = 5'h16,
    PRIM_STP_PMNAK  = 5'h17,
    PRIM_SATA_ERR   = 5'h18,
    PRIM_OTHER_K    = 5'h19
  } spc_prim_type;

  // sequence types for the transmit pattern
  typedef enum logic [2:0] {
    SEQ_SINGLE    = 3'h0,
    SEQ_REPEATED  = 3'h1,
    SEQ_CONTINUED = 3'h2,
    SEQ_TRIPLE    = 3'h3,
    SEQ_REDUNDANT = 3'h4
  } spc_seq_type;

  // dwords sent per request for each sequence type
  localparam logic [2:0] CNT_SINGLE = 3'h1;
  localparam logic [2:0] CNT_TRIPLE = 3'h3;
  localparam logic [2:0] CNT_REDUNDANT = 3'h6;
  localparam logic [2:0] CNT_REPEATED = 3'h2;
  localparam logic [2:0] CNT_CONTINUED = 3'h2;

endpackage

// >>> design/spc_codec.sv
`timescale 1ns/10ps
// What this block does
// R01: K28.5 lead; four ALIGN codings
// R02: hard reset, error, break, close, eoaf codings
// R03: aip waiting on connection coding
// R04: aip waiting on device coding
// R05: aip waiting on partial coding
// R06: reserved waiting-partial aip kept distinct
// R07: reserved change broadcast 0 recognised
// R08: reserved change broadcast 1 recognised
// R09: send pattern follows sequence type
// R10: stp flow continued; eof/cont/dmat single
// R11: pm ack/nak repeated
// R12: stp set only inside stp or sata
// R13: stp roles: initiator/host, target/device
// R14: relayed dwords pass unchanged
// R15: K28.6 dword is invalid, not primitive
// R16: error dword only from expander, outside stp
// R17: stp primitives lead with K28.3
// R18: ssp/smp primitives also lead with K28.5
// R19: unknown control dword flagged invalid
module spc_codec (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // port role and link state
  // all three are levels, held steady by the link layer
  // across a connection; they gate legality, not timing
  input wire logic is_expander_i,
  input wire logic sata_link_i,
  input wire logic stp_conn_i,
  // transmit request
  input wire logic tx_req_i,
  input wire logic [4:0] tx_prim_i,
  output logic tx_ready_o,
  output logic tx_refused_o,
  // relay path
  // a relayed dword wins the line over our own request
  input wire logic relay_valid_i,
  input wire logic [31:0] relay_dword_i,
  input wire logic [3:0] relay_k_i,
  // transmit dword, first character in bits 7:0
  output logic [31:0] tx_dword_o,
  output logic [3:0] tx_k_o,
  output logic tx_valid_o,
  // receive dword
  // same character order as the transmit side
  input wire logic rx_valid_i,
  input wire logic [31:0] rx_dword_i,
  input wire logic [3:0] rx_k_i,
  // decode result
  output logic [4:0] rx_prim_o,
  output logic rx_prim_valid_o,
  output logic rx_invalid_o
);

  // full registered state
  // one struct so every output comes straight from a flop;
  // only tx_ready_o is left combinational, as a handshake
  // output, so that back-to-back singles need no bubble
  typedef struct packed {
    logic [31:0] tx_dword;
    logic [3:0] tx_k;
    logic tx_valid;
    logic tx_refused;
    logic [2:0] remain;
    logic [4:0] rx_prim;
    logic rx_valid;
    logic rx_invalid;
  } spc_state_type;

  spc_state_type state_reg;
  spc_state_type state_next;

  // dword from three data characters after a lead control character
  // first character lands in the low byte, the order on the wire
  // and the order the receive side expects
  function automatic logic [31:0] mk(input logic [7:0] k,
    input logic [7:0] c2, input logic [7:0] c3, input logic [7:0] c4);
    mk = {c4, c3, c2, k};
  endfunction

  // primitive code to dword; zero means no encoding
  // shared by the encoder and the decoder so that both sides
  // can never disagree on a coding
  // zero is safe as a marker: no real dword is all zero,
  // since every one leads with a control character
  function automatic logic [31:0] enc(input logic [4:0] p);
    case (p)
      // align set: four variants, all with the common lead
      // the first one breaks the repeat pattern in its last
      // character, the rest repeat one data character
      spc_pkg::PRIM_ALIGN0: enc = mk(spc_pkg::K28_5, spc_pkg::D10_2,
        spc_pkg::D10_2, spc_pkg::D27_3); // R01
      spc_pkg::PRIM_ALIGN1: enc = mk(spc_pkg::K28_5, spc_pkg::D07_0,
        spc_pkg::D07_0, spc_pkg::D07_0); // R01
      spc_pkg::PRIM_ALIGN2: enc = mk(spc_pkg::K28_5, spc_pkg::D01_3,
        spc_pkg::D01_3, spc_pkg::D01_3); // R01
      spc_pkg::PRIM_ALIGN3: enc = mk(spc_pkg::K28_5, spc_pkg::D27_3,
        spc_pkg::D27_3, spc_pkg::D27_3); // R01
      // link control primitives
      // hard reset, error, break and close share a second
      // character, so the last two decide between them
      spc_pkg::PRIM_HARD_RESET: enc = mk(spc_pkg::K28_5, spc_pkg::D02_0,
        spc_pkg::D02_0, spc_pkg::D02_0); // R02
      spc_pkg::PRIM_ERROR: enc = mk(spc_pkg::K28_5, spc_pkg::D02_0,
        spc_pkg::D01_4, spc_pkg::D29_7); // R02
      spc_pkg::PRIM_BREAK: enc = mk(spc_pkg::K28_5, spc_pkg::D02_0,
        spc_pkg::D24_0, spc_pkg::D07_3); // R02
      spc_pkg::PRIM_CLOSE: enc = mk(spc_pkg::K28_5, spc_pkg::D02_0,
        spc_pkg::D30_0, spc_pkg::D27_4); // R02
      spc_pkg::PRIM_EOAF: enc = mk(spc_pkg::K28_5, spc_pkg::D24_0,
        spc_pkg::D07_3, spc_pkg::D31_4); // R02
      // arbitration in progress variants
      // all share the second character; the reserved one
      // must stay apart from the three defined ones
      spc_pkg::PRIM_AIP_CONN: enc = mk(spc_pkg::K28_5, spc_pkg::D27_4,
        spc_pkg::D07_3, spc_pkg::D24_0); // R03
      spc_pkg::PRIM_AIP_DEV: enc = mk(spc_pkg::K28_5, spc_pkg::D27_4,
        spc_pkg::D30_0, spc_pkg::D29_7); // R04
      spc_pkg::PRIM_AIP_PART: enc = mk(spc_pkg::K28_5, spc_pkg::D27_4,
        spc_pkg::D24_0, spc_pkg::D04_7); // R05
      spc_pkg::PRIM_AIP_RSVP: enc = mk(spc_pkg::K28_5, spc_pkg::D27_4,
        spc_pkg::D01_4, spc_pkg::D07_3); // R06
      // change broadcasts, one defined and two reserved
      // reserved ones are sent only so the decoder can be
      // exercised end to end
      spc_pkg::PRIM_BC_CHANGE: enc = mk(spc_pkg::K28_5, spc_pkg::D04_7,
        spc_pkg::D02_0, spc_pkg::D01_4); // R07
      spc_pkg::PRIM_BC_RSVC0: enc = mk(spc_pkg::K28_5, spc_pkg::D04_7,
        spc_pkg::D24_0, spc_pkg::D31_4); // R07
      spc_pkg::PRIM_BC_RSVC1: enc = mk(spc_pkg::K28_5, spc_pkg::D04_7,
        spc_pkg::D27_4, spc_pkg::D07_3); // R08
      // stp and sata set, with its own lead character
      // legality of these is checked outside this function
      spc_pkg::PRIM_STP_CONT: enc = mk(spc_pkg::K28_3, spc_pkg::D10_5,
        spc_pkg::D25_4, spc_pkg::D25_4); // R17
      spc_pkg::PRIM_STP_DMAT: enc = mk(spc_pkg::K28_3, spc_pkg::D21_5,
        spc_pkg::D22_1, spc_pkg::D22_1); // R17
      spc_pkg::PRIM_STP_EOF: enc = mk(spc_pkg::K28_3, spc_pkg::D21_5,
        spc_pkg::D21_6, spc_pkg::D21_6); // R17
      spc_pkg::PRIM_STP_HOLD: enc = mk(spc_pkg::K28_3, spc_pkg::D10_5,
        spc_pkg::D21_6, spc_pkg::D21_6); // R17
      spc_pkg::PRIM_STP_HOLDA: enc = mk(spc_pkg::K28_3, spc_pkg::D10_5,
        spc_pkg::D21_4, spc_pkg::D21_4); // R17
      spc_pkg::PRIM_STP_PMACK: enc = mk(spc_pkg::K28_3, spc_pkg::D21_4,
        spc_pkg::D21_4, spc_pkg::D21_4); // R17
      spc_pkg::PRIM_STP_PMNAK: enc = mk(spc_pkg::K28_3, spc_pkg::D21_4,
        spc_pkg::D21_7, spc_pkg::D21_7); // R17
      // error dword: not a primitive, but coded here so an
      // expander can originate it and the decoder can spot it
      spc_pkg::PRIM_SATA_ERR: enc = mk(spc_pkg::K28_6, spc_pkg::D02_0,
        spc_pkg::D01_4, spc_pkg::D29_7); // R17
      // none, other-control and spare codes: nothing to send
      default: enc = 32'h0000_0000;
    endcase
  endfunction

  // sequence type of each primitive
  // the type fixes how many dwords one request puts on the line
  // anything not listed goes out once
  function automatic spc_pkg::spc_seq_type seq_of(input logic [4:0] p);
    case (p)
      // the longest pattern, so a reset survives bit errors
      spc_pkg::PRIM_HARD_RESET: seq_of = spc_pkg::SEQ_REDUNDANT; // R09
      // sent three times in a row
      spc_pkg::PRIM_BC_CHANGE,
      spc_pkg::PRIM_BC_RSVC0,
      spc_pkg::PRIM_BC_RSVC1,
      spc_pkg::PRIM_CLOSE,
      spc_pkg::PRIM_BREAK: seq_of = spc_pkg::SEQ_TRIPLE; // R09
      // flow control: the link layer continues after two
      spc_pkg::PRIM_STP_HOLD,
      spc_pkg::PRIM_STP_HOLDA: seq_of = spc_pkg::SEQ_CONTINUED; // R10
      // power management answers
      spc_pkg::PRIM_STP_PMACK,
      spc_pkg::PRIM_STP_PMNAK: seq_of = spc_pkg::SEQ_REPEATED; // R11
      default: seq_of = spc_pkg::SEQ_SINGLE; // R10
    endcase
  endfunction

  // dwords to send for a sequence type
  // continued and repeated stop after two here; keeping the
  // line filled beyond that is left to the link layer, which
  // knows when the condition behind them ends
  function automatic logic [2:0] cnt_of(input spc_pkg::spc_seq_type s);
    case (s)
      spc_pkg::SEQ_TRIPLE: cnt_of = spc_pkg::CNT_TRIPLE;
      spc_pkg::SEQ_REDUNDANT: cnt_of = spc_pkg::CNT_REDUNDANT;
      spc_pkg::SEQ_REPEATED: cnt_of = spc_pkg::CNT_REPEATED;
      spc_pkg::SEQ_CONTINUED: cnt_of = spc_pkg::CNT_CONTINUED;
      default: cnt_of = spc_pkg::CNT_SINGLE;
    endcase
  endfunction

  // primitive belongs to the stp/sata set
  // relies on the stp codes being one contiguous run in the
  // package enum; a new code outside that run escapes the check
  function automatic logic is_stp(input logic [4:0] p);
    is_stp = (p >= spc_pkg::PRIM_STP_CONT) && (p <= spc_pkg::PRIM_STP_PMNAK);
  endfunction

  // codes reported as invalid dwords rather than primitives
  // used by both decoder flags so they can never overlap
  function automatic logic is_bad(input logic [4:0] c);
    is_bad = (c == spc_pkg::PRIM_SATA_ERR) || (c == spc_pkg::PRIM_OTHER_K);
  endfunction

  // decode scratch
  // combinational only; nothing here is held across edges
  logic [4:0] dec_code;
  logic tx_ok;
  logic [31:0] tx_word;

  // request legality and encoder lookup
  // legality is judged on the levels seen at the request edge;
  // a role or link change in mid-sequence does not cut the
  // sequence short, since it was legal when taken
  // an unknown code is refused as well, never sent as zero
  always_comb begin
    tx_word = enc(tx_prim_i);
    tx_ok = (tx_word != 32'h0000_0000);
    // stp set only on sata links or inside stp connection
    if (is_stp(tx_prim_i) && !(sata_link_i || stp_conn_i)) begin
      tx_ok = 1'b0; // R12
    end
    // error dword: expander only, toward sata, never in stp
    if (tx_prim_i == spc_pkg::PRIM_SATA_ERR &&
        (!is_expander_i || !sata_link_i || stp_conn_i)) begin
      tx_ok = 1'b0; // R16
    end
  end

  // receive lookup: match against every known encoding
  // a full compare of all 32 bits plus the control flags, so a
  // reserved variant never aliases a defined one
  // the loop unrolls into one comparator per code; cheap next
  // to the cost of a separate decode table
  // only the lead character may be a control character
  always_comb begin
    dec_code = spc_pkg::PRIM_NONE;
    for (int i = 1; i < 25; i++) begin
      if (rx_dword_i == enc(5'(i)) && rx_k_i == 4'h1) begin
        dec_code = 5'(i); // R06
      end
    end
    // K28.6 lead can never be a primitive
    if (rx_dword_i[7:0] == spc_pkg::K28_6 && rx_k_i[0]) begin
      dec_code = spc_pkg::PRIM_SATA_ERR; // R15
    end
    // any control character, lead or not, but no match
    if (dec_code == spc_pkg::PRIM_NONE && rx_k_i != 4'h0) begin
      dec_code = spc_pkg::PRIM_OTHER_K; // R19
    end
  end

  // ready when no sequence is in progress; relay takes priority
  // ready rises while the last dword of a sequence is on the
  // line, so the next request follows with no gap
  // everything else is a plain copy of the state register
  assign tx_ready_o = (state_reg.remain <= 3'h1) && !relay_valid_i;
  assign tx_refused_o = state_reg.tx_refused;
  assign tx_dword_o = state_reg.tx_dword;
  assign tx_k_o = state_reg.tx_k;
  assign tx_valid_o = state_reg.tx_valid;
  assign rx_prim_o = state_reg.rx_prim;
  assign rx_prim_valid_o = state_reg.rx_valid;
  assign rx_invalid_o = state_reg.rx_invalid;

  // next-state logic
  // pulses (valid, refused, decoder flags) default low and are
  // raised only by the branch that earns them
  // the sequence count runs on under a relay; a relay in the
  // middle of a sequence therefore shortens it, a limitation
  // accepted to keep the relay path free of any buffer
  always_comb begin
    state_next = state_reg;
    state_next.tx_refused = 1'b0;
    state_next.tx_valid = 1'b0;
    if (state_reg.remain != 3'h0) begin
      state_next.remain = state_reg.remain - 3'h1;
    end
    if (relay_valid_i) begin
      // forwarded as is; this end is not the originator
      state_next.tx_dword = relay_dword_i; // R14
      state_next.tx_k = relay_k_i; // R14
      state_next.tx_valid = 1'b1;
    end else if (state_reg.remain > 3'h1) begin
      // repeat the held dword for the rest of the sequence
      state_next.tx_valid = 1'b1; // R09
    end else if (tx_req_i && tx_ok) begin
      state_next.tx_dword = tx_word;
      state_next.tx_k = 4'h1; // R18
      state_next.tx_valid = 1'b1;
      state_next.remain = cnt_of(seq_of(tx_prim_i)); // R09
    end else if (tx_req_i) begin
      // illegal for this role or link, or a code with no encoding: nothing goes out
      state_next.tx_refused = 1'b1; // R13
    end
    // decoder output
    // a dword is either a primitive, an invalid dword or data
    state_next.rx_valid = rx_valid_i &&
      (dec_code != spc_pkg::PRIM_NONE) && !is_bad(dec_code); // R06
    state_next.rx_invalid = rx_valid_i && is_bad(dec_code); // R15
    // code held until the next received dword
    if (rx_valid_i) begin
      state_next.rx_prim = dec_code;
    end
  end

  // state register
  // async clear puts the line idle and the decoder silent
  // before the first clock
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// >>> bench/spc_codec_properties.sv
`timescale 1ns/10ps
// port-level checks on the primitive codec
module spc_codec_properties (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // role, link and requests
  input wire logic is_expander_i,
  input wire logic sata_link_i,
  input wire logic stp_conn_i,
  input wire logic tx_req_i,
  input wire logic [4:0] tx_prim_i,
  input wire logic tx_ready_o,
  input wire logic tx_refused_o,
  input wire logic relay_valid_i,
  input wire logic [31:0] relay_dword_i,
  input wire logic [3:0] relay_k_i,
  // line side
  input wire logic [31:0] tx_dword_o,
  input wire logic [3:0] tx_k_o,
  input wire logic tx_valid_o,
  input wire logic rx_valid_i,
  input wire logic [31:0] rx_dword_i,
  input wire logic [3:0] rx_k_i,
  input wire logic [4:0] rx_prim_o,
  input wire logic rx_prim_valid_o,
  input wire logic rx_invalid_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // own request accepted; a relay edge is left out since relay wins
  logic taken;
  assign taken = tx_req_i && tx_ready_o && !relay_valid_i;

  relay_pass_a: assert property (
    relay_valid_i |=> tx_valid_o && tx_dword_o == $past(relay_dword_i)
      && tx_k_o == $past(relay_k_i))
    else $error("relayed dword altered");
  own_lead_a: assert property (
    tx_valid_o && !$past(relay_valid_i) |-> tx_k_o == 4'h1)
    else $error("own dword lacks single control lead");
  hard_reset_len_a: assert property (
    taken && tx_prim_i == spc_pkg::PRIM_HARD_RESET |=> tx_valid_o [*6])
    else $error("redundant sequence cut short");
  close_len_a: assert property (
    taken && tx_prim_i == spc_pkg::PRIM_CLOSE |=> tx_valid_o [*3])
    else $error("triple sequence cut short");
  stp_outside_a: assert property (
    taken && tx_prim_i == spc_pkg::PRIM_STP_HOLD && !sata_link_i
      && !stp_conn_i |=> tx_refused_o && !tx_valid_o)
    else $error("stp primitive sent outside stp");
  err_dword_a: assert property (
    taken && tx_prim_i == spc_pkg::PRIM_SATA_ERR
      && (!is_expander_i || stp_conn_i) |=> tx_refused_o)
    else $error("error dword not refused");
  k286_invalid_a: assert property (
    rx_valid_i && rx_k_i[0] && rx_dword_i[7:0] == spc_pkg::K28_6
      |=> rx_invalid_o && !rx_prim_valid_o)
    else $error("k28.6 dword taken as primitive");
  error_decode_a: assert property (
    rx_valid_i && rx_k_i == 4'h1 && rx_dword_i == 32'hFD8102BC
      |=> rx_prim_valid_o && rx_prim_o == spc_pkg::PRIM_ERROR)
    else $error("error primitive not decoded");
  unknown_k_a: assert property (
    rx_valid_i && rx_k_i == 4'h1 && rx_dword_i == 32'hFFFFFFBC
      |=> rx_invalid_o)
    else $error("unlisted control dword not flagged");
  // main scenarios reached
  cover property (taken && tx_prim_i == spc_pkg::PRIM_HARD_RESET);
  cover property (relay_valid_i);
  cover property (rx_invalid_o);
endmodule

// >>> bench/spc_peer_model.sv
`timescale 1ns/10ps
// far link layer: echoes our dwords, or sends dwords handed to it
module spc_peer_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic tx_valid_i,
  input wire logic [31:0] tx_dword_i,
  input wire logic [3:0] tx_k_i,
  input wire logic inj_valid_i,
  input wire logic [31:0] inj_dword_i,
  input wire logic [3:0] inj_k_i,
  output logic rx_valid_o,
  output logic [31:0] rx_dword_o,
  output logic [3:0] rx_k_o
);
  // idle lines invert so a stale dword can never decode by luck
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_valid_o <= 1'b0;
      rx_dword_o <= 32'h00000000;
      rx_k_o <= 4'h0;
    end else if (inj_valid_i) begin
      rx_valid_o <= 1'b1;
      rx_dword_o <= inj_dword_i;
      rx_k_o <= inj_k_i;
    end else if (tx_valid_i) begin
      // coded dwords cross unchanged
      rx_valid_o <= 1'b1;
      rx_dword_o <= tx_dword_i;
      rx_k_o <= tx_k_i;
    end else begin
      rx_valid_o <= 1'b0;
      rx_dword_o <= ~rx_dword_o;
      rx_k_o <= ~rx_k_o;
    end
  end
endmodule

// >>> bench/spc_codec_bench.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("Error at %0t: got %h want %h", $time, got, exp); \
  end \
end
module spc_codec_bench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic is_expander_i = 1'b0;
  logic sata_link_i = 1'b0;
  logic stp_conn_i = 1'b0;
  logic tx_req_i = 1'b0;
  logic [4:0] tx_prim_i = 5'h00;
  logic relay_valid_i = 1'b0;
  logic [31:0] relay_dword_i = 32'h00000000;
  logic [3:0] relay_k_i = 4'h0;
  logic inj_v = 1'b0;
  logic [31:0] inj_d = 32'h00000000;
  logic [3:0] inj_k = 4'h0;
  logic tx_ready_o, tx_refused_o, tx_valid_o, rx_valid_i;
  logic rx_prim_valid_o, rx_invalid_o;
  logic [31:0] tx_dword_o, rx_dword_i;
  logic [3:0] tx_k_o, rx_k_i;
  logic [4:0] rx_prim_o;
  int failures = 0;
  int checks = 0;
  // 25 MHz system clock
  always #20 clk_sys_i = ~clk_sys_i;
  spc_codec u_spc_codec (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .is_expander_i(is_expander_i), .sata_link_i(sata_link_i),
    .stp_conn_i(stp_conn_i), .tx_req_i(tx_req_i), .tx_prim_i(tx_prim_i),
    .tx_ready_o(tx_ready_o), .tx_refused_o(tx_refused_o),
    .relay_valid_i(relay_valid_i), .relay_dword_i(relay_dword_i),
    .relay_k_i(relay_k_i), .tx_dword_o(tx_dword_o), .tx_k_o(tx_k_o),
    .tx_valid_o(tx_valid_o), .rx_valid_i(rx_valid_i),
    .rx_dword_i(rx_dword_i), .rx_k_i(rx_k_i), .rx_prim_o(rx_prim_o),
    .rx_prim_valid_o(rx_prim_valid_o), .rx_invalid_o(rx_invalid_o));
  spc_peer_model u_spc_peer_model (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .tx_valid_i(tx_valid_o), .tx_dword_i(tx_dword_o),
    .tx_k_i(tx_k_o), .inj_valid_i(inj_v), .inj_dword_i(inj_d),
    .inj_k_i(inj_k), .rx_valid_o(rx_valid_i), .rx_dword_o(rx_dword_i),
    .rx_k_o(rx_k_i));
  task automatic tally_and_finish();
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // waits, bounded, for ready, then requests for one edge
  task automatic issue(input logic [4:0] p);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    while (tx_ready_o !== 1'b1 && n < 20) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n == 20) begin
      failures++;
      tally_and_finish();
    end
    tx_prim_i = p;
    tx_req_i = 1'b1;
    @(negedge clk_sys_i);
    tx_req_i = 1'b0;
  endtask
  // sends, checks coding and length, then the echoed decode
  task automatic send(input logic [4:0] p, input logic [31:0] d,
                      input int cnt, input logic inv);
    int n;
    issue(p);
    `CHK(tx_dword_o, d)
    `CHK(tx_k_o, 4'h1)
    if (cnt > 1) `CHK(tx_ready_o, 1'b0)
    n = 0;
    while (tx_valid_o === 1'b1 && n < 10) begin
      n++;
      @(negedge clk_sys_i);
    end
    if (cnt != 0) `CHK(n, cnt)
    @(negedge clk_sys_i);
    if (inv) `CHK(rx_invalid_o, 1'b1)
    else `CHK(rx_prim_o, p)
  endtask
  task automatic refuse(input logic [4:0] p);
    issue(p);
    `CHK(tx_refused_o, 1'b1)
    `CHK(tx_valid_o, 1'b0)
  endtask
  // far side sends one dword; decode lands two edges later
  task automatic rx_one(input logic [31:0] d, input logic [4:0] p,
                        input logic inv);
    @(negedge clk_sys_i);
    inj_d = d;
    inj_k = 4'h1;
    inj_v = 1'b1;
    @(negedge clk_sys_i);
    inj_v = 1'b0;
    @(negedge clk_sys_i);
    `CHK(rx_invalid_o, inv)
    `CHK(rx_prim_valid_o, !inv)
    if (!inv) `CHK(rx_prim_o, p)
  endtask
  task automatic relay_one(input logic [31:0] d, input logic [3:0] k);
    @(negedge clk_sys_i);
    relay_dword_i = d;
    relay_k_i = k;
    relay_valid_i = 1'b1;
    @(negedge clk_sys_i);
    relay_valid_i = 1'b0;
    `CHK(tx_dword_o, d)
    `CHK(tx_k_o, k)
  endtask
  initial begin
    repeat (12) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    send(spc_pkg::PRIM_ALIGN0, 32'h7B4A4ABC, 0, 1'b0);
    send(spc_pkg::PRIM_ALIGN1, 32'h070707BC, 0, 1'b0);
    send(spc_pkg::PRIM_ALIGN2, 32'h616161BC, 0, 1'b0);
    send(spc_pkg::PRIM_ALIGN3, 32'h7B7B7BBC, 0, 1'b0);
    send(spc_pkg::PRIM_HARD_RESET, 32'h020202BC, 6, 1'b0);
    send(spc_pkg::PRIM_ERROR, 32'hFD8102BC, 1, 1'b0);
    send(spc_pkg::PRIM_BREAK, 32'h671802BC, 3, 1'b0);
    send(spc_pkg::PRIM_CLOSE, 32'h9B1E02BC, 3, 1'b0);
    send(spc_pkg::PRIM_EOAF, 32'h9F6718BC, 0, 1'b0);
    send(spc_pkg::PRIM_AIP_CONN, 32'h18679BBC, 0, 1'b0);
    send(spc_pkg::PRIM_AIP_DEV, 32'hFD1E9BBC, 0, 1'b0);
    send(spc_pkg::PRIM_AIP_PART, 32'hE4189BBC, 0, 1'b0);
    refuse(spc_pkg::PRIM_STP_HOLD);
    refuse(spc_pkg::PRIM_OTHER_K);
    refuse(spc_pkg::PRIM_SATA_ERR);
    stp_conn_i = 1'b1;
    send(spc_pkg::PRIM_STP_HOLD, 32'hD5D5AA7C, 2, 1'b0);
    send(spc_pkg::PRIM_STP_HOLDA, 32'h9595AA7C, 2, 1'b0);
    send(spc_pkg::PRIM_STP_EOF, 32'hD5D5B57C, 1, 1'b0);
    send(spc_pkg::PRIM_STP_CONT, 32'h9999AA7C, 1, 1'b0);
    send(spc_pkg::PRIM_STP_DMAT, 32'h3636B57C, 1, 1'b0);
    send(spc_pkg::PRIM_STP_PMACK, 32'h9595957C, 2, 1'b0);
    send(spc_pkg::PRIM_STP_PMNAK, 32'hF5F5957C, 2, 1'b0);
    is_expander_i = 1'b1;
    sata_link_i = 1'b1;
    refuse(spc_pkg::PRIM_SATA_ERR);
    stp_conn_i = 1'b0;
    send(spc_pkg::PRIM_SATA_ERR, 32'hFD8102DC, 1, 1'b1);
    rx_one(32'h67819BBC, spc_pkg::PRIM_AIP_RSVP, 1'b0);
    rx_one(32'h8102E4BC, spc_pkg::PRIM_BC_CHANGE, 1'b0);
    rx_one(32'h9F18E4BC, spc_pkg::PRIM_BC_RSVC0, 1'b0);
    rx_one(32'h679BE4BC, spc_pkg::PRIM_BC_RSVC1, 1'b0);
    rx_one(32'hFFFFFFBC, spc_pkg::PRIM_NONE, 1'b1);
    relay_one(32'hA5C30F96, 4'h0);
    relay_one(32'h8102E4BC, 4'h1);
    tally_and_finish();
  end
endmodule
bind spc_codec spc_codec_properties u_spc_codec_properties (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .is_expander_i(is_expander_i),
  .sata_link_i(sata_link_i), .stp_conn_i(stp_conn_i),
  .tx_req_i(tx_req_i), .tx_prim_i(tx_prim_i), .tx_ready_o(tx_ready_o),
  .tx_refused_o(tx_refused_o), .relay_valid_i(relay_valid_i),
  .relay_dword_i(relay_dword_i), .relay_k_i(relay_k_i),
  .tx_dword_o(tx_dword_o), .tx_k_o(tx_k_o), .tx_valid_o(tx_valid_o),
  .rx_valid_i(rx_valid_i), .rx_dword_i(rx_dword_i), .rx_k_i(rx_k_i),
  .rx_prim_o(rx_prim_o), .rx_prim_valid_o(rx_prim_valid_o),
  .rx_invalid_o(rx_invalid_o));
